// file: common/asp_pkg.sv
// Constants and types of the asynchronous serial port with rate divider
// Contract
// - Transmitter and receiver work independently.
// - Holding register frees receiver for next byte; in mode zero reception starts only once it is read.
// - Unread byte overwritten when next completes.
// - Eight or nine data bits, LSB first.
// - Interrupt on transmit and receive completion.
// - Drive transmit line, sample receive line.
// - Mode zero: shift register at half clock.
// - Mode one: 8-bit UART, variable rate.
// - Mode two: 9-bit UART, clock/32 or /64.
// - Mode three: 9-bit UART, variable rate.
// - Variable rate from generator or timer one.
// - Timer rate: 2^dbl*clk/(64*(256-reload)).
// - Normal divider mode stops the generator's bit rate.
// - Enabled normal divider counts up from reload.
// - Result shows count; step gives reload.
// - Divider overflow sets flag and interrupt.
// - Divider output is input/(256 - step).
`default_nettype none
package asp_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [3:0] A_CTRL          = 4'h0;
	localparam logic [3:0] A_TXDATA        = 4'h1;
	localparam logic [3:0] A_RXDATA        = 4'h2;
	localparam logic [3:0] A_STATUS        = 4'h3;
	localparam logic [3:0] A_MASK          = 4'h4;
	localparam logic [3:0] A_T1_RELOAD     = 4'h5;
	localparam logic [3:0] A_DIV_CTRL      = 4'h6;
	localparam logic [3:0] A_DIV_STEP      = 4'h7;
	localparam logic [3:0] A_DIV_RESULT    = 4'h8;
	localparam logic [3:0] A_RATE_RELOAD   = 4'h9;
	localparam logic [3:0] A_RATE_PRESCALE = 4'ha;
	// ==========================================================
	// Field positions
	localparam int C_MODE     = 0;
	localparam int C_RX_EN    = 2;
	localparam int C_DBL      = 3;
	localparam int C_SRC_GEN  = 4;
	localparam int C_TX_BIT9  = 5;
	localparam int ST_TX      = 0;
	localparam int ST_RX      = 1;
	localparam int ST_DIV     = 2;
	localparam int ST_OVR     = 3;
	localparam int ST_RX_BIT9 = 4;
	localparam int ST_TX_BUSY = 5;
	localparam int D_EN       = 0;
	localparam int D_NORM     = 1;
	localparam int D_OVF      = 2;
	// ==========================================================
	// Reset values
	localparam logic [5:0] CTRL_RST        = 6'h00;
	localparam logic [3:0] MASK_RST        = 4'h0;
	localparam logic [7:0] T1_RELOAD_RST   = 8'h00;
	localparam logic [1:0] DIV_CTRL_RST    = 2'h0;
	localparam logic [7:0] STEP_RST        = 8'h00;
	localparam logic [7:0] RATE_RELOAD_RST = 8'h00;
	localparam logic [2:0] PRESCALE_RST    = 3'h0;
	// ==========================================================
	// Modes and timing
	typedef enum logic [1:0] {
		MODE_SHIFT     = 2'h0,
		MODE_UART8     = 2'h1,
		MODE_UART9_FIX = 2'h2,
		MODE_UART9_VAR = 2'h3
	} asp_mode_t;
	localparam logic [3:0] OVS_MID   = 4'h7;
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT9 = 4'h8;
endpackage
`default_nettype wire

// file: rtl/asp_rate_gen.sv
// Prescaler, fractional divider and dedicated baud generator
`default_nettype none
module asp_rate_gen
	import asp_pkg::*;
#(
	parameter int unsigned W = 8
) (
	// Clock, reset and enable
	input  wire logic         clk_sys_i,
	input  wire logic         nrst_i,
	input  wire logic         ce_i,
	// Configuration
	input  wire logic         div_en_i,
	input  wire logic         div_normal_i,
	input  wire logic [W-1:0] step_i,
	input  wire logic [W-1:0] reload_i,
	input  wire logic [2:0]   prescale_i,
	// Results
	output logic      [W-1:0] result_o,
	output logic              ovf_o,
	output logic              gen_tick_o
);
	logic [6:0]   pre_q;
	logic [W-1:0] res_q;
	logic [W-1:0] baud_q;
	logic [W:0]   frac_sum;
	logic [6:0]   pre_mask;
	logic         pre_tick;
	logic         run_frac;
	logic         run_norm;
	logic         in_tick;
	logic         run_q;

	// ==========================================================
	// Input pulse and divider modes
	assign pre_mask   = ~(7'h7f << prescale_i);
	assign pre_tick   = &(pre_q | ~pre_mask);
	assign run_frac   = div_en_i & ~div_normal_i;
	assign run_norm   = div_en_i & div_normal_i;
	assign frac_sum   = {1'b0, res_q} + {1'b0, step_i};
	// Fractional carry paces the generator; bypassed while the divider is off
	assign in_tick    = run_frac ? (pre_tick & frac_sum[W]) : pre_tick;
	assign ovf_o      = run_norm & run_q & pre_tick & (&res_q);
	assign gen_tick_o = ~div_normal_i & in_tick & (baud_q == '0);
	assign result_o   = res_q;

	// ==========================================================
	// Counters
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_q  <= 7'h00;
			res_q  <= '0;
			baud_q <= '0;
			run_q  <= 1'b0;
		end else if (ce_i) begin
			pre_q <= pre_q + 7'h01;
			run_q <= run_norm;
			// The first count after enabling starts at the reload value
			if (run_norm && !run_q) begin
				res_q <= step_i;
			end else if (run_norm && pre_tick) begin
				res_q <= (&res_q) ? step_i : res_q + W'(1);
			end else if (run_frac && pre_tick) begin
				res_q <= frac_sum[W-1:0];
			end
			if (in_tick && !div_normal_i) begin
				baud_q <= (baud_q == '0) ? reload_i : baud_q - W'(1);
			end
		end
	end

	// ==========================================================
	// Checks
	a_normal_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i || !ce_i)
		run_norm && run_q && pre_tick && !(&res_q) |=> res_q == $past(res_q) + W'(1))
		else $error("normal divider did not count up");
endmodule
`default_nettype wire

// file: rtl/asp_top.sv
// Asynchronous serial port with baud sources and normal divider timer
`default_nettype none
module asp_top
	import asp_pkg::*;
(
	// Clock, reset and enable
	input  wire logic       clk_sys_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	// Register port
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Serial lines
	input  wire logic       rxd_i,
	output logic            txd_o,
	output logic            shift_clk_o,
	// Interrupt
	output logic            irq_o
);
	typedef enum logic [3:0] {
		S_IDLE  = 4'h1,
		S_START = 4'h2,
		S_DATA  = 4'h4,
		S_STOP  = 4'h8
	} asp_ser_st_t;

	function automatic logic asp_hit(input logic strobe, input logic [3:0] a,
		input logic [3:0] k);
		return strobe & (a == k);
	endfunction

	function automatic logic asp_nine(input asp_mode_t m);
		return (m == MODE_UART9_FIX) || (m == MODE_UART9_VAR);
	endfunction

	// Registers
	logic [5:0]  ctrl_q;
	logic [3:0]  mask_q;
	logic [7:0]  t1rl_q;
	logic [1:0]  divc_q;
	logic        div_flag_q;
	logic [7:0]  step_q;
	logic [7:0]  rate_rl_q;
	logic [2:0]  presc_q;
	logic [7:0]  rx_buf_q;
	logic        rx_b9_q;
	logic        rx_full_q;
	logic [7:0]  rd_data_q;
	logic        irq_q;
	logic        txd_q;
	logic        sclk_q;
	// Baud timing
	logic        ph_q;
	logic [1:0]  m2_q;
	logic [7:0]  t1_q;
	logic        t1_half_q;
	// Transmitter and receiver
	asp_ser_st_t tx_st_q;
	asp_ser_st_t rx_st_q;
	logic [8:0]  tx_sh_q;
	logic [8:0]  rx_sh_q;
	logic [3:0]  tx_cnt_q;
	logic [3:0]  rx_cnt_q;
	logic [3:0]  tx_sub_q;
	logic [3:0]  rx_sub_q;
	logic        rx_s1_q;
	logic        rx_s2_q;
	logic        rx_prev_q;
	// Wires
	asp_mode_t   mode;
	logic        m_shift;
	logic        m_fix;
	logic        wr_ctrl, wr_tx, wr_mask, wr_t1, wr_divc, wr_step, wr_rl, wr_pre;
	logic        rd_rx, rd_st;
	logic        t1_ovf, t1_tick, m2_tick, gen_tick, tick16;
	logic        div_ovf;
	logic [7:0]  div_res;
	logic        tx_go, tx_adv, tx_done, tx_busy;
	logic [3:0]  tx_last, rx_last;
	logic        rx_fall, rx_mid, rx_store, rx_nine, ovr_ev;
	logic [7:0]  rx_word;
	logic        txd_d;
	logic [3:0]  ev;
	logic [3:0]  st_w;
	logic [7:0]  rd_mux;

	// ==========================================================
	// Address decode
	assign mode    = asp_mode_t'(ctrl_q[C_MODE +: 2]);
	assign m_shift = (mode == MODE_SHIFT);
	assign m_fix   = (mode == MODE_UART9_FIX);
	assign wr_ctrl = asp_hit(reg_wr_i, reg_addr_i, A_CTRL);
	assign wr_tx   = asp_hit(reg_wr_i, reg_addr_i, A_TXDATA);
	assign wr_mask = asp_hit(reg_wr_i, reg_addr_i, A_MASK);
	assign wr_t1   = asp_hit(reg_wr_i, reg_addr_i, A_T1_RELOAD);
	assign wr_divc = asp_hit(reg_wr_i, reg_addr_i, A_DIV_CTRL);
	assign wr_step = asp_hit(reg_wr_i, reg_addr_i, A_DIV_STEP);
	assign wr_rl   = asp_hit(reg_wr_i, reg_addr_i, A_RATE_RELOAD);
	assign wr_pre  = asp_hit(reg_wr_i, reg_addr_i, A_RATE_PRESCALE);
	assign rd_rx   = asp_hit(reg_rd_i, reg_addr_i, A_RXDATA);
	assign rd_st   = asp_hit(reg_rd_i, reg_addr_i, A_STATUS);

	// ==========================================================
	// Baud sources: 16 ticks per bit in the asynchronous modes
	assign t1_ovf  = ph_q & (&t1_q);
	assign t1_tick = t1_ovf & (ctrl_q[C_DBL] | t1_half_q);
	assign m2_tick = ctrl_q[C_DBL] ? m2_q[0] : (&m2_q);
	assign tick16  = m_fix ? m2_tick
		: (ctrl_q[C_SRC_GEN] ? gen_tick : t1_tick);

	asp_rate_gen #(
		.W (8)
	) u_rate_gen (
		.clk_sys_i    (clk_sys_i),
		.nrst_i       (nrst_i),
		.ce_i         (ce_i),
		.div_en_i     (divc_q[D_EN]),
		.div_normal_i (divc_q[D_NORM]),
		.step_i       (step_q),
		.reload_i     (rate_rl_q),
		.prescale_i   (presc_q),
		.result_o     (div_res),
		.ovf_o        (div_ovf),
		.gen_tick_o   (gen_tick)
	);

	// Timer one runs at half the clock and reloads from its reload byte
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ph_q      <= 1'b0;
			m2_q      <= 2'h0;
			t1_q      <= T1_RELOAD_RST;
			t1_half_q <= 1'b0;
		end else if (ce_i) begin
			ph_q <= ~ph_q;
			m2_q <= m2_q + 2'h1;
			if (ph_q) t1_q <= t1_ovf ? t1rl_q : t1_q + 8'h01;
			if (t1_ovf) t1_half_q <= ~t1_half_q;
		end
	end

	// ==========================================================
	// Transmitter
	assign tx_busy = (tx_st_q != S_IDLE);
	assign tx_go   = wr_tx & ~tx_busy;
	assign tx_last = asp_nine(mode) ? LAST_BIT9 : LAST_BIT8;
	assign tx_adv  = m_shift ? tx_sub_q[0] : (tick16 & (tx_sub_q == OVS_LAST));
	assign tx_done = tx_adv & ((tx_st_q == S_STOP)
		| (m_shift & (tx_st_q == S_DATA) & (tx_cnt_q == tx_last)));
	assign txd_d   = (tx_st_q == S_START) ? 1'b0
		: ((tx_st_q == S_DATA) ? tx_sh_q[0] : 1'b1);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_st_q  <= S_IDLE;
			tx_sh_q  <= 9'h000;
			tx_cnt_q <= 4'h0;
			tx_sub_q <= 4'h0;
		end else if (ce_i) begin
			if (tx_busy && (m_shift || tick16)) tx_sub_q <= tx_sub_q + 4'h1;
			unique case (tx_st_q)
			S_IDLE: if (tx_go) begin
				tx_sh_q  <= {ctrl_q[C_TX_BIT9], reg_wdata_i};
				tx_cnt_q <= 4'h0;
				tx_sub_q <= 4'h0;
				tx_st_q  <= m_shift ? S_DATA : S_START;
			end
			S_START: if (tx_adv) tx_st_q <= S_DATA;
			S_DATA: if (tx_adv) begin
				tx_sh_q  <= tx_sh_q >> 1;
				tx_cnt_q <= tx_cnt_q + 4'h1;
				if (tx_cnt_q == tx_last) tx_st_q <= m_shift ? S_IDLE : S_STOP;
			end
			S_STOP: if (tx_adv) tx_st_q <= S_IDLE;
			default: tx_st_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receiver
	assign rx_nine  = asp_nine(mode);
	assign rx_last  = rx_nine ? LAST_BIT9 : LAST_BIT8;
	assign rx_fall  = rx_prev_q & ~rx_s2_q;
	assign rx_mid   = m_shift ? rx_sub_q[0] : (tick16 & (rx_sub_q == OVS_MID));
	assign rx_store = (rx_st_q == S_STOP) & (m_shift | rx_mid);
	assign rx_word  = rx_nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
	assign ovr_ev   = rx_store & rx_full_q & ~rd_rx;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_s1_q   <= 1'b1;
			rx_s2_q   <= 1'b1;
			rx_prev_q <= 1'b1;
		end else if (ce_i) begin
			rx_s1_q   <= rxd_i;
			rx_s2_q   <= rx_s1_q;
			rx_prev_q <= rx_s2_q;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_st_q  <= S_IDLE;
			rx_sh_q  <= 9'h000;
			rx_cnt_q <= 4'h0;
			rx_sub_q <= 4'h0;
		end else if (ce_i) begin
			if (rx_st_q != S_IDLE && (m_shift || tick16)) rx_sub_q <= rx_sub_q + 4'h1;
			unique case (rx_st_q)
			S_IDLE: if (ctrl_q[C_RX_EN] && (m_shift ? !rx_full_q : rx_fall)) begin
				rx_sub_q <= 4'h0;
				rx_cnt_q <= 4'h0;
				rx_st_q  <= m_shift ? S_DATA : S_START;
			end
			S_START: if (rx_mid) rx_st_q <= rx_s2_q ? S_IDLE : S_DATA;
			S_DATA: if (rx_mid) begin
				rx_sh_q  <= {rx_s2_q, rx_sh_q[8:1]};
				rx_cnt_q <= rx_cnt_q + 4'h1;
				if (rx_cnt_q == rx_last) rx_st_q <= S_STOP;
			end
			S_STOP: if (rx_store) rx_st_q <= S_IDLE;
			default: rx_st_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Sticky status, read clears, an event in the same cycle wins
	assign ev = {ovr_ev, div_ovf, rx_store, tx_done};
	for (genvar i = 0; i < 4; i++) begin : g_st
		logic b_q;
		always_ff @(posedge clk_sys_i or negedge nrst_i) begin
			if (!nrst_i) b_q <= 1'b0;
			else if (ce_i) b_q <= ev[i] | (b_q & ~rd_st);
		end
		assign st_w[i] = b_q;
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q     <= CTRL_RST;
			mask_q     <= MASK_RST;
			t1rl_q     <= T1_RELOAD_RST;
			divc_q     <= DIV_CTRL_RST;
			div_flag_q <= 1'b0;
			step_q     <= STEP_RST;
			rate_rl_q  <= RATE_RELOAD_RST;
			presc_q    <= PRESCALE_RST;
			rx_buf_q   <= 8'h00;
			rx_b9_q    <= 1'b0;
			rx_full_q  <= 1'b0;
		end else if (ce_i) begin
			if (wr_ctrl) ctrl_q <= reg_wdata_i[5:0];
			if (wr_mask) mask_q <= reg_wdata_i[3:0];
			if (wr_t1) t1rl_q <= reg_wdata_i;
			if (wr_divc) divc_q <= reg_wdata_i[1:0];
			if (wr_step) step_q <= reg_wdata_i;
			if (wr_rl) rate_rl_q <= reg_wdata_i;
			if (wr_pre) presc_q <= reg_wdata_i[2:0];
			div_flag_q <= div_ovf
				| (div_flag_q & ~(wr_divc & ~reg_wdata_i[D_OVF]));
			if (rx_store) begin
				rx_buf_q  <= rx_word;
				rx_b9_q   <= rx_nine & rx_sh_q[8];
				rx_full_q <= 1'b1;
			end else if (rd_rx) begin
				rx_full_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read data and outputs
	assign rd_mux =
		(reg_addr_i == A_CTRL)          ? {2'b00, ctrl_q} :
		(reg_addr_i == A_RXDATA)        ? rx_buf_q :
		(reg_addr_i == A_STATUS)        ? {2'b00, tx_busy, rx_b9_q, st_w} :
		(reg_addr_i == A_MASK)          ? {4'h0, mask_q} :
		(reg_addr_i == A_T1_RELOAD)     ? t1rl_q :
		(reg_addr_i == A_DIV_CTRL)      ? {5'h00, div_flag_q, divc_q} :
		(reg_addr_i == A_DIV_STEP)      ? step_q :
		(reg_addr_i == A_DIV_RESULT)    ? div_res :
		(reg_addr_i == A_RATE_RELOAD)   ? rate_rl_q :
		(reg_addr_i == A_RATE_PRESCALE) ? {5'h00, presc_q} : 8'h00;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_q <= 8'h00;
			irq_q     <= 1'b0;
			txd_q     <= 1'b1;
			sclk_q    <= 1'b1;
		end else if (ce_i) begin
			rd_data_q <= reg_rd_i ? rd_mux : 8'h00;
			irq_q     <= |(st_w & mask_q);
			txd_q     <= txd_d;
			sclk_q    <= (m_shift && tx_busy) ? tx_sub_q[0]
				: ((m_shift && rx_st_q != S_IDLE) ? rx_sub_q[0] : 1'b1);
		end
	end

	assign reg_rdata_o = rd_data_q;
	assign txd_o       = txd_q;
	assign shift_clk_o = sclk_q;
	assign irq_o       = irq_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i || !ce_i);

	a_tx_start_low: assert property (tx_go && !m_shift |-> ##2 !txd_o)
		else $error("start bit not low");
	a_tx_idle_high: assert property (!tx_busy ##1 !tx_busy |=> txd_o)
		else $error("idle line not high");
	a_shift_rate: assert property (m_shift && tx_st_q == S_DATA && tx_adv |=> !tx_adv)
		else $error("shift bit shorter than two clocks");
	a_rx_hold: assert property (rx_store |=> rx_full_q && rx_buf_q == $past(rx_word))
		else $error("received byte not held");
	a_rx_overrun: assert property (rx_store && rx_full_q && !rd_rx |=> st_w[ST_OVR])
		else $error("overrun not flagged");
	a_done_irq: assert property (tx_done && mask_q[ST_TX] && !wr_mask |-> ##2 irq_o)
		else $error("transmit done did not interrupt");
	a_normal_no_rate: assert property (divc_q[D_NORM] && ctrl_q[C_SRC_GEN] && !m_fix |-> !tick16)
		else $error("rate tick in normal divider mode");
	a_div_flag_set: assert property (div_ovf |=> div_flag_q && st_w[ST_DIV])
		else $error("divider overflow not flagged");
	a_rx_read_data: assert property (rd_rx |=> reg_rdata_o == $past(rx_buf_q))
		else $error("receive read returned wrong data");

	c_tx_frame: cover property (tx_done && !m_shift);
	c_rx_frame: cover property (rx_store && !m_shift);
	c_overrun: cover property (ovr_ev);
	c_div_ovf: cover property (div_ovf ##1 irq_o);
endmodule
`default_nettype wire

// file: verification/asp_remote.sv
// Remote serial transceiver model facing the port's serial lines
`default_nettype none
module asp_remote (
	// Clock
	input  wire logic clk_i,
	// Serial lines
	input  wire logic txd_i,
	output logic      rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int         bit_clks = 32;
	int         nbits    = 8;
	int         frames   = 0;
	logic [8:0] got      = 9'h000;
	logic       frame_ok = 1'b0;
	initial rxd_o = 1'b1;
	// ==========================================================
	// Sender: start low, data LSB first, stop high, line idles high
	task automatic send(input int n, input logic [8:0] v);
		@(posedge clk_i) rxd_o <= 1'b0;
		repeat (bit_clks) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rxd_o <= v[i];
			repeat (bit_clks) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
		repeat (bit_clks) @(posedge clk_i);
	endtask
	// ==========================================================
	// Receiver: samples each bit of a frame at its middle
	initial forever begin : rx_proc
		logic ok;
		@(negedge txd_i);
		got = 9'h000;
		repeat (bit_clks / 2) @(posedge clk_i);
		ok = (txd_i === 1'b0);
		for (int i = 0; i < nbits; i++) begin
			repeat (bit_clks) @(posedge clk_i);
			got[i] = txd_i;
		end
		repeat (bit_clks) @(posedge clk_i);
		frame_ok = ok && (txd_i === 1'b1);
		frames++;
	end
endmodule
`default_nettype wire

// file: verification/tb_async_serial_port_with_divider.sv
// Self-checking testbench of the asynchronous serial port
`default_nettype none
module tb_async_serial_port_with_divider;
	import asp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys_i = 1'b0;
	logic       nrst_i    = 1'b0;
	logic       ce_i      = 1'b1;
	logic [3:0] reg_addr_i  = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic       reg_wr_i    = 1'b0;
	logic       reg_rd_i    = 1'b0;
	logic [7:0] reg_rdata_o;
	logic       rxd, txd_o, shift_clk_o, irq_o;
	int         err_total = 0;
	int         tests_run = 0;
	int         cyc       = 0;
	logic [7:0] d;
	// ==========================================================
	// Clock, design and far side
	initial forever #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) cyc <= cyc + 1;
	asp_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rxd_i(rxd), .txd_o(txd_o),
		.shift_clk_o(shift_clk_o), .irq_o(irq_o));
	asp_remote remote (.clk_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd));
	// ==========================================================
	// Bus cycles and comparison
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_frame(input int n0);
		for (int i = 0; i < 1000 && remote.frames <= n0; i++) @(posedge clk_sys_i);
		check("frame seen", 1, remote.frames > n0);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		check("txd idle", 1, txd_o);
		check("irq idle", 0, irq_o);
		rd(A_MASK, d);
		check("mask", 0, d);
		rd(4'hf, d);
		check("unmapped", 0, d);
		$display("test reset done");
	endtask
	// One frame per rate source and mode, all set up for 32 clocks per bit
	task automatic t_modes;
		logic [7:0] ctl [3] = '{8'h2e, 8'h0d, 8'h37};
		int         nb  [3] = '{9, 8, 9};
		logic [8:0] v;
		int         n0;
		wr(A_T1_RELOAD, 8'hff);
		// Timer one counts up from zero once before the reload applies
		repeat (520) @(posedge clk_sys_i);
		wr(A_RATE_RELOAD, 8'h01);
		wr(A_RATE_PRESCALE, 8'h00);
		for (int k = 0; k < 3; k++) begin
			v = 9'h0a5 + k * 9'h033;
			v[8] = ctl[k][C_TX_BIT9] & (nb[k] == 9);
			remote.nbits = nb[k];
			n0 = remote.frames;
			wr(A_CTRL, ctl[k]);
			wr(A_TXDATA, v[7:0]);
			wait_frame(n0);
			check("tx frame", v, remote.got);
			check("tx framing", 1, remote.frame_ok);
			// The remote finishes at mid stop bit; the port a half bit later
			repeat (24) @(posedge clk_sys_i);
			rd(A_STATUS, d);
			check("tx done", 1, d[ST_TX]);
		end
		$display("test modes done");
	endtask
	task automatic t_duplex;
		int n0;
		n0 = remote.frames;
		remote.nbits = 9;
		wr(A_CTRL, 8'h2e);
		wr(A_MASK, 8'h03);
		fork
			wr(A_TXDATA, 8'h5a);
			remote.send(9, 9'h13c);
		join
		wait_frame(n0);
		repeat (40) @(posedge clk_sys_i);
		check("tx during rx", 9'h15a, remote.got);
		check("irq raised", 1, irq_o);
		rd(A_STATUS, d);
		check("rx done", 1, d[ST_RX]);
		check("rx bit9", 1, d[ST_RX_BIT9]);
		rd(A_RXDATA, d);
		check("rx byte", 8'h3c, d);
		repeat (2) @(posedge clk_sys_i);
		check("irq cleared", 0, irq_o);
		$display("test duplex done");
	endtask
	task automatic t_overrun;
		remote.send(9, 9'h011);
		remote.send(9, 9'h122);
		repeat (40) @(posedge clk_sys_i);
		rd(A_STATUS, d);
		check("overrun", 1, d[ST_OVR]);
		rd(A_RXDATA, d);
		check("newer kept", 8'h22, d);
		$display("test overrun done");
	endtask
	task automatic t_divider;
		int r1;
		int n0;
		wr(A_MASK, 8'h04);
		wr(A_DIV_STEP, 8'hf0);
		wr(A_DIV_CTRL, 8'h03);
		n0 = remote.frames;
		wr(A_CTRL, 8'h37);
		wr(A_TXDATA, 8'h66);
		for (int i = 0; i < 100 && irq_o !== 1'b1; i++) @(posedge clk_sys_i);
		r1 = cyc;
		rd(A_STATUS, d);
		check("div status", 1, d[ST_DIV]);
		for (int i = 0; i < 10 && irq_o !== 1'b0; i++) @(posedge clk_sys_i);
		for (int i = 0; i < 100 && irq_o !== 1'b1; i++) @(posedge clk_sys_i);
		check("div period", 16, cyc - r1);
		rd(A_DIV_CTRL, d);
		check("div flag", 1, d[D_OVF]);
		rd(A_DIV_RESULT, d);
		check("result range", 1, d >= 8'hf0);
		// A low clock enable must hold the read data instead of clearing it
		ce_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		check("frozen rdata", d, reg_rdata_o);
		ce_i <= 1'b1;
		repeat (400) @(posedge clk_sys_i);
		rd(A_STATUS, d);
		check("no rate", 0, d[ST_TX]);
		check("tx held", 1, d[ST_TX_BUSY]);
		remote.nbits = 9;
		wr(A_DIV_CTRL, 8'h00);
		// The held start bit misframes the remote; let both settle first
		repeat (800) @(posedge clk_sys_i);
		n0 = remote.frames;
		wr(A_TXDATA, 8'h66);
		wait_frame(n0);
		check("frame after", 9'h166, remote.got);
		$display("test divider done");
	endtask
	task automatic t_shift;
		logic [7:0] got;
		int         last;
		wr(A_MASK, 8'h00);
		wr(A_CTRL, 8'h00);
		wr(A_TXDATA, 8'h96);
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 20 && shift_clk_o !== 1'b0; j++) @(posedge clk_sys_i);
			for (int j = 0; j < 20 && shift_clk_o !== 1'b1; j++) @(posedge clk_sys_i);
			got[i] = txd_o;
			if (i > 0)
				check("shift period", 2, cyc - last);
			last = cyc;
		end
		check("shift byte", 8'h96, got);
		$display("test shift done");
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		t_reset();
		t_modes();
		t_duplex();
		t_overrun();
		t_divider();
		t_shift();
		report_and_stop();
	end
	initial begin
		#1ms;
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
